// ### rtl/tpc_pkg.sv
// Shared constants for the timer pin and clock control block
package tpc_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W = 10;
	localparam int INT_W = 5;

	// Register byte addresses
	localparam logic [7:0] OFS_ROUTE = 8'h00;
	localparam logic [7:0] OFS_CTRL0 = 8'h04;
	localparam logic [7:0] OFS_CTRL1 = 8'h08;
	localparam logic [7:0] OFS_CMPA0 = 8'h0c;
	localparam logic [7:0] OFS_CMPP0 = 8'h10;
	localparam logic [7:0] OFS_CMPA1 = 8'h14;
	localparam logic [7:0] OFS_CMPB1 = 8'h18;
	localparam logic [7:0] OFS_CMPP1 = 8'h1c;
	localparam logic [7:0] OFS_INTSTAT = 8'h20;
	localparam logic [7:0] OFS_INTCLR = 8'h24;
	localparam logic [7:0] OFS_INTEN = 8'h28;
	localparam logic [7:0] OFS_COUNT0 = 8'h2c;
	localparam logic [7:0] OFS_COUNT1 = 8'h30;
	localparam logic [7:0] OFS_PORTINV = 8'h34;

	// Pin route register layout per variant
	localparam logic [7:0] ROUTE_MASK_SMALL = 8'h31;
	localparam logic [7:0] ROUTE_RST_SMALL = 8'h11;
	localparam logic [7:0] ROUTE_MASK_LARGE = 8'hb3;
	localparam logic [7:0] ROUTE_RST_LARGE = 8'h91;
	localparam int RB_T0_FIRST = 0;
	localparam int RB_T0_SECOND = 1;
	localparam int RB_T1_FIRST = 4;
	localparam int RB_T1_SECOND = 5;
	localparam int RB_T1_CHAN_A = 7;

	// Timer control register fields
	localparam int CF_SEL_LO = 0;
	localparam int CF_ON = 3;
	localparam int CF_MODE_LO = 4;
	localparam int CF_ACT_LO = 6;
	localparam int CF_INIT = 8;
	localparam int CF_CLRA = 9;
	localparam int CTRL_W = 10;

	// Interrupt status bits
	localparam int IB_T0A = 0;
	localparam int IB_T0P = 1;
	localparam int IB_T1A = 2;
	localparam int IB_T1P = 3;
	localparam int IB_T1B = 4;

	// Prescaler ratios
	localparam logic [5:0] DIV4_MASK = 6'h03;
	localparam logic [5:0] DIV16_MASK = 6'h0f;
	localparam logic [5:0] DIV64_MASK = 6'h3f;
	localparam logic [10:0] CNT_FULL = 11'h400;
	localparam int SYS_CLK_HZ = 250000000;
	localparam int LOW_CLK_HZ = 32768;

	typedef enum logic [2:0] {
		SEL_SYS4 = 3'b000,
		SEL_SYS = 3'b001,
		SEL_HIGH16 = 3'b010,
		SEL_HIGH64 = 3'b011,
		SEL_LOW = 3'b100,
		SEL_NONE = 3'b101,
		SEL_PIN_RISE = 3'b110,
		SEL_PIN_FALL = 3'b111
	} tpc_clk_sel_t;

	typedef enum logic [1:0] {
		MODE_COMPARE = 2'b00,
		MODE_TIMER = 2'b01,
		MODE_PWM = 2'b10,
		MODE_SPARE = 2'b11
	} tpc_mode_t;

	typedef enum logic [1:0] {
		ACT_NONE = 2'b00,
		ACT_LOW = 2'b01,
		ACT_HIGH = 2'b10,
		ACT_TOGGLE = 2'b11
	} tpc_act_t;
endpackage

// ### rtl/tpc_timer_if.sv
// Control and status bundle between the register block and one timer core
`timescale 1ns/1ns
interface tpc_timer_if;
	import tpc_pkg::*;
	logic tick;
	logic on;
	tpc_mode_t mode;
	tpc_act_t act;
	logic initLvl;
	logic clrOnA;
	logic [CNT_W-1:0] cmpA;
	logic [CNT_W-1:0] cmpB;
	logic [2:0] cmpP;
	logic [CNT_W-1:0] count;
	logic matchA;
	logic matchB;
	logic matchP;
	logic outA;
	logic outB;
	modport ctrl (output tick, on, mode, act, initLvl, clrOnA, cmpA, cmpB, cmpP,
		input count, matchA, matchB, matchP, outA, outB);
	modport core (input tick, on, mode, act, initLvl, clrOnA, cmpA, cmpB, cmpP,
		output count, matchA, matchB, matchP, outA, outB);
endinterface

// ### rtl/tpc_timer_core.sv
// Ten-bit timer counter with comparators A, B, P and output waveform logic
`timescale 1ns/1ns
module tpc_timer_core import tpc_pkg::*; #(
	parameter bit HAS_B = 1'b1
) (
	input wire logic mclk,
	input wire logic arst_n,
	tpc_timer_if.core tif
);
	logic onDly;
	logic hitA;
	logic hitB;
	logic hitP;
	logic [10:0] pLimit;

	function automatic logic applyAct(input logic cur, input tpc_act_t act);
		case (act)
			ACT_LOW: applyAct = 1'b0;
			ACT_HIGH: applyAct = 1'b1;
			ACT_TOGGLE: applyAct = !cur;
			default: applyAct = cur;
		endcase
	endfunction

	// P of zero means a full 1024-count period
	always_comb begin
		pLimit = (tif.cmpP == 3'h0) ? CNT_FULL : {1'b0, tif.cmpP, 7'h00};
		hitA = tif.on && tif.tick && (tif.count == tif.cmpA);
		hitB = HAS_B && tif.on && tif.tick && (tif.count == tif.cmpB);
		hitP = tif.on && tif.tick && ({1'b0, tif.count} == pLimit - 11'h001);
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			onDly <= 1'b0;
			tif.count <= '0;
		end else begin
			onDly <= tif.on;
			if (tif.on && !onDly) begin
				tif.count <= '0;
			end else if (hitP || (hitA && tif.clrOnA)) begin
				tif.count <= '0; // R4
			end else if (tif.on && tif.tick) begin
				tif.count <= tif.count + 10'h001;
			end
		end
	end

	// Match pulses feed the sticky interrupt flags
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tif.matchA <= 1'b0;
			tif.matchB <= 1'b0;
			tif.matchP <= 1'b0;
		end else begin
			tif.matchA <= hitA; // R5
			tif.matchB <= hitB; // R6
			tif.matchP <= hitP; // R5
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tif.outA <= 1'b0;
			tif.outB <= 1'b0;
		end else if (tif.on && !onDly) begin
			tif.outA <= tif.initLvl;
			tif.outB <= tif.initLvl;
		end else if (tif.mode == MODE_COMPARE) begin
			if (hitA) begin
				tif.outA <= applyAct(tif.outA, tif.act); // R7
			end
			if (hitB) begin
				tif.outB <= applyAct(tif.outB, tif.act); // R7
			end
		end else if (tif.mode == MODE_PWM && tif.on) begin
			tif.outA <= (tif.count < tif.cmpA) ? tif.initLvl : !tif.initLvl; // R8
			tif.outB <= (tif.count < tif.cmpB) ? tif.initLvl : !tif.initLvl; // R8
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	sequence highMatch;
		hitA && tif.mode == MODE_COMPARE && tif.act == ACT_HIGH && !(tif.on && !onDly);
	endsequence

	cmpOutHigh_a: assert property (highMatch |=> tif.outA) // R7
		else $error("compare match did not drive output high");
	toggleOut_a: assert property (hitA && tif.mode == MODE_COMPARE && tif.act == ACT_TOGGLE
		&& !(tif.on && !onDly) |=> tif.outA != $past(tif.outA)) // R7
		else $error("compare match did not toggle output");
	periodClear_a: assert property (hitP |=> tif.count == '0) // R4
		else $error("period match did not clear counter");
endmodule

// ### rtl/tpc_timer_pin_ctrl.sv
// Register block, clock selection, interrupts and pin routing for two timers
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
// Function
// R1: Select code 101 stops the counter clock
// R2: Clock from system, high, low or pin
// R3: Pin clock counts rising or falling edges
// R4: Comparator match interrupts, may clear, drive output
// R5: Compact/standard timer: A and P interrupts
// R6: Enhanced timer: A, B and P interrupts
// R7: Compare mode sets, clears or toggles output
// R8: PWM waveform appears on timer output pins
// R9: Route bit 1 gives pin to timer
// R10: Small variant uses bits 5, 4, 0
// R11: Large variant uses bits 7, 5, 4, 1, 0
// R12: Unimplemented route bits read zero, ignore writes
// R13: Software enables at most one capture input
// R14: Port data bit inverts each output pin
// R15: Route write acts from next cycle; here the registered pinOut and pinOe follow one cycle after the route register
module tpc_timer_pin_ctrl import tpc_pkg::*; #(
	parameter bit LARGE_VARIANT = 1'b1,
	parameter int LOW_CLK_DIV = SYS_CLK_HZ / LOW_CLK_HZ
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic tckPin0,
	input wire logic tckPin1,
	input wire logic [7:0] altOut,
	input wire logic [7:0] altOe,
	output logic [7:0] pinOut,
	output logic [7:0] pinOe,
	output logic irq
);
	localparam logic [7:0] ROUTE_MASK = LARGE_VARIANT ? ROUTE_MASK_LARGE : ROUTE_MASK_SMALL;
	localparam logic [7:0] ROUTE_RST = LARGE_VARIANT ? ROUTE_RST_LARGE : ROUTE_RST_SMALL;
	localparam logic [15:0] LOW_TOP = 16'(LOW_CLK_DIV - 1);

	logic [7:0] route;
	logic [7:0] portInv;
	logic [CTRL_W-1:0] ctrl0;
	logic [CTRL_W-1:0] ctrl1;
	logic [CNT_W-1:0] cmpA0;
	logic [2:0] cmpP0;
	logic [CNT_W-1:0] cmpA1;
	logic [CNT_W-1:0] cmpB1;
	logic [2:0] cmpP1;
	logic [INT_W-1:0] intEn;
	logic [INT_W-1:0] intStat;
	logic [INT_W-1:0] next_intStat;
	logic [INT_W-1:0] intEvents;
	logic [INT_W-1:0] intClr;
	logic wrCommit;
	logic [5:0] preCnt;
	logic [15:0] lowCnt;
	logic lowTick;
	logic [2:0] tck0Sync;
	logic [2:0] tck1Sync;
	logic [7:0] timerSig;
	logic [7:0] next_pinOut;
	logic [7:0] next_pinOe;

	tpc_timer_if t0 ();
	tpc_timer_if t1 ();

	function automatic logic [15:0] mergeBe(input logic [15:0] old, input logic [DATA_W-1:0] wd,
		input logic [3:0] be);
		mergeBe = old;
		if (be[0]) begin
			mergeBe[7:0] = wd[7:0];
		end
		if (be[1]) begin
			mergeBe[15:8] = wd[15:8];
		end
	endfunction

	// One tick decision shared by both timers
	function automatic logic selTick(input logic [2:0] sel, input logic [5:0] pre, input logic lowT,
		input logic [2:0] pinS);
		case (tpc_clk_sel_t'(sel))
			SEL_SYS4: selTick = (pre & DIV4_MASK) == DIV4_MASK; // R2
			SEL_SYS: selTick = 1'b1; // R2
			SEL_HIGH16: selTick = (pre & DIV16_MASK) == DIV16_MASK; // R2
			SEL_HIGH64: selTick = pre == DIV64_MASK; // R2
			SEL_LOW: selTick = lowT; // R2
			SEL_PIN_RISE: selTick = pinS[1] && !pinS[2]; // R3
			SEL_PIN_FALL: selTick = !pinS[1] && pinS[2]; // R3
			default: selTick = 1'b0; // R1
		endcase
	endfunction

	assign wrCommit = avs_write && !avs_waitrequest;

	// One wait state: request seen, answer at the following edge
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			avs_readdata <= '0;
		end else if (avs_read && avs_waitrequest) begin
			case (avs_address)
				OFS_ROUTE: avs_readdata <= {24'h000000, route & ROUTE_MASK}; // R12
				OFS_CTRL0: avs_readdata <= {22'h000000, ctrl0};
				OFS_CTRL1: avs_readdata <= {22'h000000, ctrl1};
				OFS_CMPA0: avs_readdata <= {22'h000000, cmpA0};
				OFS_CMPP0: avs_readdata <= {29'h00000000, cmpP0};
				OFS_CMPA1: avs_readdata <= {22'h000000, cmpA1};
				OFS_CMPB1: avs_readdata <= {22'h000000, cmpB1};
				OFS_CMPP1: avs_readdata <= {29'h00000000, cmpP1};
				OFS_INTSTAT: avs_readdata <= {27'h0000000, intStat};
				OFS_INTEN: avs_readdata <= {27'h0000000, intEn};
				OFS_COUNT0: avs_readdata <= {22'h000000, t0.count};
				OFS_COUNT1: avs_readdata <= {22'h000000, t1.count};
				OFS_PORTINV: avs_readdata <= {24'h000000, portInv & ROUTE_MASK};
				default: avs_readdata <= '0;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			route <= ROUTE_RST; // R10 R11
			portInv <= '0;
		end else if (wrCommit && avs_byteenable[0]) begin
			if (avs_address == OFS_ROUTE) begin
				route <= avs_writedata[7:0] & ROUTE_MASK; // R12 R15
			end
			if (avs_address == OFS_PORTINV) begin
				portInv <= avs_writedata[7:0] & ROUTE_MASK;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl0 <= '0;
			ctrl1 <= '0;
			cmpA0 <= '0;
			cmpP0 <= '0;
			cmpA1 <= '0;
			cmpB1 <= '0;
			cmpP1 <= '0;
			intEn <= '0;
		end else if (wrCommit) begin
			case (avs_address)
				OFS_CTRL0: ctrl0 <= CTRL_W'(mergeBe(16'(ctrl0), avs_writedata, avs_byteenable));
				OFS_CTRL1: ctrl1 <= CTRL_W'(mergeBe(16'(ctrl1), avs_writedata, avs_byteenable));
				OFS_CMPA0: cmpA0 <= CNT_W'(mergeBe(16'(cmpA0), avs_writedata, avs_byteenable));
				OFS_CMPP0: cmpP0 <= 3'(mergeBe(16'(cmpP0), avs_writedata, avs_byteenable));
				OFS_CMPA1: cmpA1 <= CNT_W'(mergeBe(16'(cmpA1), avs_writedata, avs_byteenable));
				OFS_CMPB1: cmpB1 <= CNT_W'(mergeBe(16'(cmpB1), avs_writedata, avs_byteenable));
				OFS_CMPP1: cmpP1 <= 3'(mergeBe(16'(cmpP1), avs_writedata, avs_byteenable));
				OFS_INTEN: intEn <= INT_W'(mergeBe(16'(intEn), avs_writedata, avs_byteenable));
				default: ;
			endcase
		end
	end

	// Prescalers: high internal clock taken as the system clock
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			preCnt <= '0;
			lowCnt <= '0;
			lowTick <= 1'b0;
		end else begin
			preCnt <= preCnt + 6'h01;
			lowTick <= lowCnt == LOW_TOP;
			lowCnt <= (lowCnt == LOW_TOP) ? 16'h0000 : lowCnt + 16'h0001;
		end
	end

	// Pin clocks are asynchronous; only stage 2 and 3 feed edge logic
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			tck0Sync <= '0;
			tck1Sync <= '0;
		end else begin
			tck0Sync <= {tck0Sync[1:0], tckPin0};
			tck1Sync <= {tck1Sync[1:0], tckPin1};
		end
	end

	always_comb begin
		t0.tick = selTick(ctrl0[CF_SEL_LO +: 3], preCnt, lowTick, tck0Sync); // R1 R2 R3
		t0.on = ctrl0[CF_ON];
		t0.mode = tpc_mode_t'(ctrl0[CF_MODE_LO +: 2]);
		t0.act = tpc_act_t'(ctrl0[CF_ACT_LO +: 2]);
		t0.initLvl = ctrl0[CF_INIT];
		t0.clrOnA = ctrl0[CF_CLRA];
		t0.cmpA = cmpA0;
		t0.cmpB = '0;
		t0.cmpP = cmpP0;
		t1.tick = selTick(ctrl1[CF_SEL_LO +: 3], preCnt, lowTick, tck1Sync); // R1 R2 R3
		t1.on = ctrl1[CF_ON];
		t1.mode = tpc_mode_t'(ctrl1[CF_MODE_LO +: 2]);
		t1.act = tpc_act_t'(ctrl1[CF_ACT_LO +: 2]);
		t1.initLvl = ctrl1[CF_INIT];
		t1.clrOnA = ctrl1[CF_CLRA];
		t1.cmpA = cmpA1;
		t1.cmpB = cmpB1;
		t1.cmpP = cmpP1;
	end

	tpc_timer_core #(.HAS_B(1'b0)) u_timer0 (
		.mclk(mclk),
		.arst_n(arst_n),
		.tif(t0.core)
	);

	tpc_timer_core #(.HAS_B(LARGE_VARIANT)) u_timer1 (
		.mclk(mclk),
		.arst_n(arst_n),
		.tif(t1.core)
	);

	// Sticky status; a match in the clear cycle still sets its bit
	always_comb begin
		intEvents = '0;
		intEvents[IB_T0A] = t0.matchA; // R4 R5
		intEvents[IB_T0P] = t0.matchP; // R5
		intEvents[IB_T1A] = t1.matchA; // R5 R6
		intEvents[IB_T1P] = t1.matchP; // R5 R6
		intEvents[IB_T1B] = LARGE_VARIANT && t1.matchB; // R6
		intClr = (wrCommit && avs_address == OFS_INTCLR && avs_byteenable[0]) ? avs_writedata[INT_W-1:0] : '0;
		next_intStat = (intStat & ~intClr) | intEvents;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			intStat <= '0;
			irq <= 1'b0;
		end else begin
			intStat <= next_intStat;
			irq <= |(next_intStat & intEn);
		end
	end

	// Timer signal feeding each route bit position
	always_comb begin
		timerSig = '0;
		timerSig[RB_T0_FIRST] = t0.outA;
		if (LARGE_VARIANT) begin
			timerSig[RB_T0_SECOND] = t0.outA;
			timerSig[RB_T1_FIRST] = t1.outB;
			timerSig[RB_T1_SECOND] = t1.outB;
			timerSig[RB_T1_CHAN_A] = t1.outA;
		end else begin
			timerSig[RB_T1_FIRST] = t1.outA;
			timerSig[RB_T1_SECOND] = t1.outA;
		end
		next_pinOut = (route & (timerSig ^ portInv)) | (~route & altOut); // R9 R14
		next_pinOe = route | (~route & altOe); // R9
	end

	// Registered pins add one cycle but keep outputs glitch free
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pinOut <= '0;
			pinOe <= '0;
		end else begin
			pinOut <= next_pinOut; // R8 R15
			pinOe <= next_pinOe; // R15
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	sequence routeWrite;
		wrCommit && avs_address == OFS_ROUTE && avs_byteenable[0];
	endsequence

	sequence routeRead;
		avs_read && avs_waitrequest && avs_address == OFS_ROUTE;
	endsequence

	noClock_a: assert property (ctrl0[CF_SEL_LO +: 3] == SEL_NONE |-> !t0.tick) // R1
		else $error("disconnected clock still ticks");
	sysDiv4_a: assert property (ctrl0[CF_SEL_LO +: 3] == SEL_SYS4 && t0.tick
		|=> (!t0.tick || ctrl0[CF_SEL_LO +: 3] != SEL_SYS4) [*3]) // R2
		else $error("divide by four ticks too often");
	pinRise_a: assert property (ctrl0[CF_SEL_LO +: 3] == SEL_PIN_RISE && $rose(tck0Sync[1])
		|-> t0.tick) // R3
		else $error("pin rising edge not counted");
	pinFall_a: assert property (ctrl1[CF_SEL_LO +: 3] == SEL_PIN_FALL && $fell(tck1Sync[1])
		|-> t1.tick) // R3
		else $error("pin falling edge not counted");
	matchIrqA_a: assert property (t0.matchA |=> intStat[IB_T0A]) // R4
		else $error("compare A match lost");
	matchIrqP_a: assert property (t1.matchP |=> intStat[IB_T1P]) // R5
		else $error("compare P match lost");
	matchIrqB_a: assert property (LARGE_VARIANT && t1.matchB |=> intStat[IB_T1B]) // R6
		else $error("compare B match lost");
	routePin_a: assert property (routeWrite |=> ##1 pinOe[RB_T0_FIRST] == (route[RB_T0_FIRST]
		|| $past(altOe[RB_T0_FIRST]))) // R15
		else $error("route write not applied next cycle");
	routeBits_a: assert property (routeRead |=> (avs_readdata[7:0] & ~ROUTE_MASK) == 8'h00) // R12
		else $error("unimplemented route bit reads nonzero");
	invertPin_a: assert property (route[RB_T0_FIRST] |=> pinOut[RB_T0_FIRST]
		== ($past(t0.outA) ^ $past(portInv[RB_T0_FIRST]))) // R14
		else $error("output inversion wrong");
	routeReset_a: assert property ($rose(arst_n) |-> route == ROUTE_RST) // R10
		else $error("route reset value wrong");
	irqLevel_a: assert property (irq == |(intStat & $past(intEn))) // R4
		else $error("interrupt level disagrees with enabled status");

	sequence statClear0;
		intClr[IB_T0A] && !t0.matchA;
	endsequence

	intClear_a: assert property (statClear0 |=> !intStat[IB_T0A]) // R4
		else $error("status clear not applied");
	routeOe_a: assert property (route[RB_T1_CHAN_A] |=> pinOe[RB_T1_CHAN_A]) // R9
		else $error("routed pin not driven");
	altPin_a: assert property (!route[RB_T0_SECOND] |=> pinOut[RB_T0_SECOND]
		== $past(altOut[RB_T0_SECOND])) // R9
		else $error("unrouted pin lost other function value");
	altOe_a: assert property (!route[RB_T0_SECOND] |=> pinOe[RB_T0_SECOND]
		== $past(altOe[RB_T0_SECOND])) // R9
		else $error("unrouted pin lost other function enable");
	chanAPin_a: assert property (LARGE_VARIANT && route[RB_T1_CHAN_A] |=> pinOut[RB_T1_CHAN_A]
		== ($past(t1.outA) ^ $past(portInv[RB_T1_CHAN_A]))) // R11
		else $error("timer one channel A pin wrong");
endmodule

// ### tb/tpc_pin_partner.sv
// Far-side pin model: timer clock inputs and the other-function pin drive
`timescale 1ns/1ns
module tpc_pin_partner (
	input wire logic mclk,
	output logic tckPin0,
	output logic tckPin1,
	output logic [7:0] altOut,
	output logic [7:0] altOe
);
	initial begin
		tckPin0 = 1'b0;
		tckPin1 = 1'b0;
		// Pattern differs per bit so a wrong mux select shows
		altOut = 8'h5a;
		altOe = 8'h42;
	end

	// Pulses high 4 cycles, low 4; wide enough for the two-flop synchroniser
	// Only one timer input toggles at a time
	task automatic pulse(input int pin, input int n);
		repeat (n) begin
			@(posedge mclk);
			if (pin == 0) tckPin0 <= 1'b1;
			else tckPin1 <= 1'b1;
			repeat (4) @(posedge mclk);
			if (pin == 0) tckPin0 <= 1'b0;
			else tckPin1 <= 1'b0;
			repeat (3) @(posedge mclk);
		end
	endtask
endmodule

// ### tb/tpc_timer_pin_ctrl_tb.sv
// Self-checking bench for the timer pin and clock control block
`timescale 1ns/1ns
module tpc_timer_pin_ctrl_tb;
	import tpc_pkg::*;
	logic mclk;
	logic arst_n;
	logic [ADDR_W-1:0] addr;
	logic rd;
	logic wr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic [DATA_W-1:0] got;
	logic waitReq;
	logic irq;
	logic tck0;
	logic tck1;
	logic [7:0] altOut;
	logic [7:0] altOe;
	logic [7:0] pinOut;
	logic [7:0] pinOe;
	logic [7:0] pinOutSmall;
	logic [7:0] pinOeSmall;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	int hi;
	int i;

	tpc_timer_pin_ctrl #(.LARGE_VARIANT(1'b1), .LOW_CLK_DIV(8)) i_dut (
		.mclk(mclk), .arst_n(arst_n), .avs_address(addr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(waitReq),
		.tckPin0(tck0), .tckPin1(tck1), .altOut(altOut), .altOe(altOe),
		.pinOut(pinOut), .pinOe(pinOe), .irq(irq)
	);

	tpc_pin_partner i_pins (.mclk(mclk), .tckPin0(tck0), .tckPin1(tck1), .altOut(altOut), .altOe(altOe));

	// Small variant kept idle; only its reset pin layout is looked at
	tpc_timer_pin_ctrl #(.LARGE_VARIANT(1'b0)) i_dut_small (
		.mclk(mclk), .arst_n(arst_n), .avs_address(8'h00), .avs_read(1'b0), .avs_write(1'b0),
		.avs_writedata(32'h0), .avs_byteenable(4'h0), .avs_readdata(), .avs_waitrequest(),
		.tckPin0(tck0), .tckPin1(tck1), .altOut(altOut), .altOe(altOe),
		.pinOut(pinOutSmall), .pinOe(pinOeSmall), .irq()
	);

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// Hang guard; the whole run needs well under a third of this
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			wrap_up;
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Request held until waitrequest is sampled low; released at that edge
	task automatic busWr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		while (waitReq !== 1'b0) @(posedge mclk);
		wr <= 1'b0;
	endtask

	task automatic busRd(input logic [7:0] a);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		while (waitReq !== 1'b0) @(posedge mclk);
		got = rdata;
		rd <= 1'b0;
	endtask

	task automatic settle;
		@(posedge mclk);
		#1;
	endtask

	initial begin
		arst_n = 1'b0;
		addr = '0;
		rd = 1'b0;
		wr = 1'b0;
		wdata = '0;
		repeat (4) @(posedge mclk);
		arst_n <= 1'b1;

		busRd(OFS_ROUTE);
		check("route reset", got, 32'h91);
		check("oe reset", {24'h0, pinOe}, 32'hd3);
		check("alt out", {24'h0, pinOut & 8'h6e}, 32'h4a);
		check("small oe reset", {24'h0, pinOeSmall}, 32'h53);
		check("small out reset", {24'h0, pinOutSmall}, 32'h4a);
		$display("done: reset");

		busWr(OFS_ROUTE, 32'hff);
		settle;
		check("oe all", {24'h0, pinOe}, 32'hf3);
		busRd(OFS_ROUTE);
		check("route masked", got, 32'hb3);
		busWr(OFS_ROUTE, 32'h0);
		settle;
		check("oe none", {24'h0, pinOe}, 32'h42);
		check("out none", {24'h0, pinOut}, 32'h5a);
		busWr(8'h3c, 32'hffff);
		busRd(8'h3c);
		check("unmapped", got, 32'h0);
		busWr(OFS_ROUTE, 32'h01);
		$display("done: routing");

		// Codes 000 to 101; only 101 leaves the counter still
		for (i = 0; i < 6; i++) begin
			busWr(OFS_CTRL0, 32'h0);
			busWr(OFS_CTRL0, 32'h8 | i);
			repeat (300) @(posedge mclk);
			busRd(OFS_COUNT0);
			check("count moves", got != 0, i != 5);
		end
		$display("done: clock select");

		// Timer0 on rising pin edges, timer1 on falling ones
		for (i = 0; i < 2; i++) begin
			busWr(i ? OFS_CTRL1 : OFS_CTRL0, 32'h0);
			busWr(i ? OFS_CTRL1 : OFS_CTRL0, 32'h8 | (6 + i));
			i_pins.pulse(i, 7);
			repeat (10) @(posedge mclk);
			busRd(i ? OFS_COUNT1 : OFS_COUNT0);
			check("pin edges", got, 32'h7);
		end
		$display("done: pin clock");

		// One match at count 5 within the wait; period 128 keeps it single
		busWr(OFS_CMPA0, 32'h5);
		busWr(OFS_CMPP0, 32'h1);
		for (i = 0; i < 4; i++) begin
			busWr(OFS_CTRL0, 32'h0);
			busWr(OFS_CTRL0, 32'h9 | (i << 6) | ((i == 2 ? 0 : 1) << 8));
			repeat (20) @(posedge mclk);
			#1;
			check("match out", pinOut[0], i == 0 || i == 2);
		end
		busWr(OFS_PORTINV, 32'h1);
		settle;
		check("inverted", pinOut[0], 1'b1);
		busWr(OFS_PORTINV, 32'h0);
		$display("done: compare output");

		busWr(OFS_CMPA0, 32'd64);
		busWr(OFS_CTRL0, 32'h0);
		busWr(OFS_CTRL0, 32'h29);
		repeat (20) @(posedge mclk);
		hi = 0;
		repeat (256) begin
			@(posedge mclk);
			hi += (pinOut[0] === 1'b1);
		end
		check("pwm duty", hi >= 120 && hi <= 136, 1'b1);
		$display("done: pwm");

		// Timer mode with toggle action and clear on A: pin holds, count wraps at 5
		busWr(OFS_CMPA0, 32'h5);
		busWr(OFS_CTRL0, 32'h0);
		busWr(OFS_CTRL0, 32'h2d9);
		repeat (50) @(posedge mclk);
		busRd(OFS_COUNT0);
		check("clear on A", got <= 5, 1'b1);
		check("timer mode out", pinOut[0], 1'b0);
		$display("done: clear on A");

		busWr(OFS_CTRL0, 32'h0);
		busWr(OFS_INTEN, 32'h0);
		busWr(OFS_INTCLR, 32'h1f);
		busWr(OFS_CMPA0, 32'h5);
		busWr(OFS_CMPA1, 32'h3);
		busWr(OFS_CMPB1, 32'h6);
		busWr(OFS_CMPP1, 32'h1);
		busWr(OFS_CTRL0, 32'h9);
		busWr(OFS_CTRL1, 32'h9);
		repeat (200) @(posedge mclk);
		busWr(OFS_CTRL0, 32'h0);
		busWr(OFS_CTRL1, 32'h0);
		busRd(OFS_INTSTAT);
		check("all sources", got, 32'h1f);
		check("irq masked", irq, 1'b0);
		busWr(OFS_INTEN, 32'h1f);
		repeat (2) settle;
		check("irq on", irq, 1'b1);
		busWr(OFS_INTCLR, 32'h1);
		busRd(OFS_INTSTAT);
		check("one cleared", got, 32'h1e);
		busWr(OFS_INTCLR, 32'h1e);
		repeat (2) settle;
		check("irq off", irq, 1'b0);
		busRd(OFS_INTSTAT);
		check("all cleared", got, 32'h0);
		$display("done: interrupts");

		// Second reset in mid-run restores the route defaults
		@(posedge mclk);
		arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		busRd(OFS_ROUTE);
		check("route rereset", got, 32'h91);
		$display("done: second reset");
		wrap_up;
	end
endmodule
